// ===== logic/spa_array.sv
// Purpose: Programmable AND array with eight macrocells, set up over AXI4-Lite
// Assumes: Pins are asynchronous to clk_in; software halts the array before reprogramming
// Notes: Pin outputs lag the array by one register; pins pass two sync stages
//
// Contract
// [R1] The AND array sees 36 lines, true and complement of 10 inputs and 8 input/feedback signals.
// [R2] The array has 74 product terms: 64 logic terms, 8 output enables, one preset and one clear.
// [R3] Every line and term crossing has its own connect setting and a term ANDs all connected lines.
// [R4] The 64 logic terms form eight groups of eight, each ORed into the sum of one macrocell.
// [R5] Each macrocell flip-flop captures its sum on the rising clock and its true or inverted value is usable.
// [R6] While the clear term is high every flip-flop output goes low at once; the code drops q_r at the next rising edge, its feedback at once.
// [R7] When the preset term is high every flip-flop becomes high at the next rising edge.
// [R8] With clear and preset both high the clear wins and the flip-flops stay low.
// [R9] Power-up clears every macrocell flip-flop.
// [R10] Each macrocell has four configuration bits of its own picking one of twelve configurations.
// [R11] Bit A picks polarity (1 active low) and bit B the source (1 registered, 0 combinatorial).
// [R12] Bits C and D pick feedback: both 1 pin, C 1 and D 0 sum, both 0 register.
// [R13] The output enable term drives the pin while high and leaves it undriven while low.
// [R14] A pin serves as input or bidirectional, and outside logic drives it only while its enable is low.
// [R15] Clock, preset term and clear term are shared by all eight macrocells.
// [R16] Connection settings and configuration bits stay fixed during normal running.
`timescale 1ns/1ns
`default_nettype none
module spa_array (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic [9:0] din_in,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out_out,
    output logic [7:0] pin_oe_out,
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in
);
    logic [17:0] meta_r, sync_r;
    logic [35:0] fuse_r [spa_pkg::N_TERMS];
    logic [35:0] lines;
    logic [17:0] sig;
    logic [73:0] term;
    logic [7:0] sum, fb, q_all;
    spa_pkg::spa_glob_t glob;

    logic run_r, run_nxt;
    logic [6:0] tsel_r, tsel_nxt;
    logic [31:0] cfg_r, cfg_nxt;
    logic fuse_we;
    logic [35:0] fuse_wdata, fuse_cur;
    logic tsel_ok;

    logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
    logic [7:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic awready_r, awready_nxt, wready_r, wready_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = val[8*b +: 8];
            end
        end
        return res;
    endfunction : merge

    // Pin and input synchroniser
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= {pin_in, din_in};
            sync_r <= meta_r;
        end
    end

    always_comb begin
        sig = {fb, sync_r[9:0]};
        for (int i = 0; i < spa_pkg::N_SIG; i++) begin
            lines[2*i] = sig[i]; // see [R1]
            lines[2*i+1] = ~sig[i];
        end
    end

    // Halted array yields all-low terms, so pins float and flops clear
    genvar t;
    generate
        for (t = 0; t < spa_pkg::N_TERMS; t++) begin : g_term
            assign term[t] = run_r & (&(~fuse_r[t] | lines)); // see [R3]
        end
    endgenerate

    assign glob = spa_pkg::spa_glob_t'({term[spa_pkg::T_PRESET], term[spa_pkg::T_CLEAR]}); // see [R15]

    genvar m;
    generate
        for (m = 0; m < spa_pkg::N_IO; m++) begin : g_cell
            assign sum[m] = |term[m*spa_pkg::TERMS_PER_SUM +: spa_pkg::TERMS_PER_SUM]; // see [R4]
            spa_macrocell u_cell (
                .clk_in(clk_in),
                .reset_n_in(reset_n_in),
                .sum_in(sum[m]),
                .oe_term_in(term[spa_pkg::T_OE_BASE + m]), // see [R2]
                .glob_in(glob),
                .cfg_in(spa_pkg::spa_cfg_t'(cfg_r[spa_pkg::CFG_BITS*m +: spa_pkg::CFG_BITS])), // see [R10]
                .pin_sync_in(sync_r[spa_pkg::N_DIN + m]), // see [R14]
                .fb_out(fb[m]),
                .q_out(q_all[m]),
                .pin_out(pin_out_out[m]),
                .oe_out(pin_oe_out[m])
            );
        end
    endgenerate

    assign tsel_ok = tsel_r <= spa_pkg::TSEL_LAST;
    assign fuse_cur = tsel_ok ? fuse_r[tsel_r] : spa_pkg::FUSE_RST;

    // Write channel and register updates
    always_comb begin
        aw_hold_nxt = aw_hold_r;
        w_hold_nxt = w_hold_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        run_nxt = run_r;
        tsel_nxt = tsel_r;
        cfg_nxt = cfg_r;
        fuse_we = 1'b0;
        fuse_wdata = fuse_cur;
        if (s_axi_awvalid_in && awready_r) begin
            aw_hold_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && wready_r) begin
            w_hold_nxt = 1'b1;
            wdata_nxt = s_axi_wdata_in;
            wstrb_nxt = s_axi_wstrb_in;
        end
        if (bvalid_r && s_axi_bready_in) begin
            bvalid_nxt = 1'b0;
        end
        if (aw_hold_r && w_hold_r && !bvalid_r) begin
            aw_hold_nxt = 1'b0;
            w_hold_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = spa_pkg::RESP_OKAY;
            unique case ({awaddr_r[7:2], 2'b00})
                spa_pkg::A_CTRL: begin
                    if (wstrb_r[0]) begin
                        run_nxt = wdata_r[spa_pkg::CTRL_RUN_BIT];
                    end
                end
                spa_pkg::A_TSEL: begin
                    if (wstrb_r[0]) begin
                        tsel_nxt = wdata_r[6:0];
                    end
                end
                spa_pkg::A_FUSE_LO: begin
                    if (run_r || !tsel_ok) begin
                        bresp_nxt = spa_pkg::RESP_SLVERR; // see [R16]
                    end else begin
                        fuse_we = 1'b1;
                        fuse_wdata = {fuse_cur[35:32], merge(fuse_cur[31:0], wdata_r, wstrb_r)};
                    end
                end
                spa_pkg::A_FUSE_HI: begin
                    if (run_r || !tsel_ok) begin
                        bresp_nxt = spa_pkg::RESP_SLVERR;
                    end else begin
                        fuse_we = 1'b1;
                        fuse_wdata = {(wstrb_r[0] ? wdata_r[3:0] : fuse_cur[35:32]), fuse_cur[31:0]};
                    end
                end
                spa_pkg::A_CFG: begin
                    if (run_r) begin
                        bresp_nxt = spa_pkg::RESP_SLVERR; // see [R16]
                    end else begin
                        cfg_nxt = merge(cfg_r, wdata_r, wstrb_r);
                    end
                end
                default: bresp_nxt = spa_pkg::RESP_SLVERR;
            endcase
        end
        awready_nxt = !aw_hold_nxt && !bvalid_nxt;
        wready_nxt = !w_hold_nxt && !bvalid_nxt;
    end

    // Read channel
    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (rvalid_r && s_axi_rready_in) begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid_in && arready_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = spa_pkg::RESP_OKAY;
            rdata_nxt = 32'h0000_0000;
            unique case ({s_axi_araddr_in[7:2], 2'b00})
                spa_pkg::A_CTRL: rdata_nxt[spa_pkg::CTRL_RUN_BIT] = run_r;
                spa_pkg::A_TSEL: rdata_nxt[6:0] = tsel_r;
                spa_pkg::A_FUSE_LO: begin
                    rdata_nxt = fuse_cur[31:0];
                    rresp_nxt = tsel_ok ? spa_pkg::RESP_OKAY : spa_pkg::RESP_SLVERR;
                end
                spa_pkg::A_FUSE_HI: begin
                    rdata_nxt[3:0] = fuse_cur[35:32];
                    rresp_nxt = tsel_ok ? spa_pkg::RESP_OKAY : spa_pkg::RESP_SLVERR;
                end
                spa_pkg::A_CFG: rdata_nxt = cfg_r;
                spa_pkg::A_STAT: rdata_nxt[23:0] = {sync_r[17:10], pin_oe_out, q_all};
                default: rresp_nxt = spa_pkg::RESP_SLVERR;
            endcase
        end
        arready_nxt = !rvalid_nxt;
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            for (int i = 0; i < spa_pkg::N_TERMS; i++) begin
                fuse_r[i] <= spa_pkg::FUSE_RST;
            end
        end else if (fuse_we) begin
            fuse_r[tsel_r] <= fuse_wdata;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            run_r <= spa_pkg::CTRL_RUN_RST;
            tsel_r <= spa_pkg::TSEL_RST;
            cfg_r <= spa_pkg::CFG_RST;
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= spa_pkg::RESP_OKAY;
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= spa_pkg::RESP_OKAY;
        end else begin
            run_r <= run_nxt;
            tsel_r <= tsel_nxt;
            cfg_r <= cfg_nxt;
            aw_hold_r <= aw_hold_nxt;
            w_hold_r <= w_hold_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    assign s_axi_awready_out = awready_r;
    assign s_axi_wready_out = wready_r;
    assign s_axi_bvalid_out = bvalid_r;
    assign s_axi_bresp_out = bresp_r;
    assign s_axi_arready_out = arready_r;
    assign s_axi_rvalid_out = rvalid_r;
    assign s_axi_rdata_out = rdata_r;
    assign s_axi_rresp_out = rresp_r;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    property p_run_gate;
        !run_r |-> term == '0 ##1 (pin_oe_out == 8'h00);
    endproperty
    a_run_gate: assert property (p_run_gate) else $error("halted array produced terms"); // see [R2]

    property p_power_up;
        $rose(reset_n_in) |-> q_all == 8'h00 && pin_oe_out == 8'h00;
    endproperty
    a_power_up: assert property (p_power_up) else $error("flops not clear after reset"); // see [R9]

    property p_cfg_static;
        run_r && $past(run_r) |-> $stable(cfg_r) && !$past(fuse_we);
    endproperty
    a_cfg_static: assert property (p_cfg_static) else $error("setup changed while running"); // see [R16]

    property p_full_fuse;
        fuse_r[spa_pkg::T_CLEAR] == spa_pkg::FUSE_RST |-> !glob.clear;
    endproperty
    a_full_fuse: assert property (p_full_fuse) else $error("fully connected term not low"); // see [R3]

    property p_sum_group;
        (term[7:0] == 8'h00 |-> !sum[0]) and (term[8] |-> sum[1]);
    endproperty
    a_sum_group: assert property (p_sum_group) else $error("sum grouping wrong"); // see [R4]

    property p_shared_clear;
        glob.clear |=> q_all == 8'h00;
    endproperty
    a_shared_clear: assert property (p_shared_clear) else $error("clear not shared"); // see [R15]
endmodule : spa_array
`default_nettype wire

// ===== logic/spa_macrocell.sv
// Purpose: One I/O macrocell: D flip-flop, output and feedback selection
// Assumes: Clear and preset terms come from logic on the same clock
// Notes: Combinatorial feedback is taken one cycle late to avoid a loop
`timescale 1ns/1ns
`default_nettype none
module spa_macrocell (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic sum_in,
    input wire logic oe_term_in,
    input wire spa_pkg::spa_glob_t glob_in,
    input wire spa_pkg::spa_cfg_t cfg_in,
    input wire logic pin_sync_in,
    output logic fb_out,
    output logic q_out,
    output logic pin_out,
    output logic oe_out
);
    logic q_r, q_nxt;
    logic comb_r, comb_nxt;
    logic pin_r, pin_nxt;
    logic oe_r, oe_nxt;
    logic q_eff;
    logic fb;
    spa_pkg::spa_fb_t fb_sel;

    always_comb begin
        fb_sel = spa_pkg::spa_fb_t'({cfg_in.fb_d, cfg_in.fb_c});
        q_eff = q_r & ~glob_in.clear; // see [R6]
        if (glob_in.clear) begin
            q_nxt = 1'b0; // see [R8]
        end else if (glob_in.preset) begin
            q_nxt = 1'b1; // see [R7]
        end else begin
            q_nxt = sum_in; // see [R5]
        end
        comb_nxt = sum_in;
        pin_nxt = (cfg_in.src_reg ? q_nxt : sum_in) ^ cfg_in.pol_low; // see [R11]
        oe_nxt = oe_term_in; // see [R13]
        unique case (fb_sel)
            spa_pkg::SPA_FB_PIN: fb = pin_sync_in; // see [R12]
            spa_pkg::SPA_FB_COMB: fb = comb_r;
            default: fb = q_eff;
        endcase
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            q_r <= 1'b0; // see [R9]
            comb_r <= 1'b0;
            pin_r <= 1'b0;
            oe_r <= 1'b0;
        end else begin
            q_r <= q_nxt;
            comb_r <= comb_nxt;
            pin_r <= pin_nxt;
            oe_r <= oe_nxt;
        end
    end

    assign fb_out = fb;
    assign q_out = q_r;
    assign pin_out = pin_r;
    assign oe_out = oe_r;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    property p_clear_low;
        glob_in.clear |-> (fb_sel[0] || !fb_out) ##1 (!q_r && (!cfg_in.src_reg || pin_r == cfg_in.pol_low));
    endproperty
    a_clear_low: assert property (p_clear_low) else $error("clear did not drop register"); // see [R6]

    property p_preset_high;
        glob_in.preset && !glob_in.clear |=> q_r;
    endproperty
    a_preset_high: assert property (p_preset_high) else $error("preset did not set register"); // see [R7]

    property p_clear_wins;
        glob_in.preset && glob_in.clear |=> !q_r;
    endproperty
    a_clear_wins: assert property (p_clear_wins) else $error("preset beat clear"); // see [R8]

    property p_capture;
        !glob_in.preset && !glob_in.clear |=> q_r == $past(sum_in);
    endproperty
    a_capture: assert property (p_capture) else $error("register missed sum"); // see [R5]

    property p_comb_out;
        !cfg_in.src_reg ##1 !cfg_in.src_reg |-> pin_r == ($past(sum_in) ^ $past(cfg_in.pol_low));
    endproperty
    a_comb_out: assert property (p_comb_out) else $error("combinatorial output wrong"); // see [R11]

    property p_reg_out;
        cfg_in.src_reg ##1 cfg_in.src_reg |-> pin_r == (q_r ^ $past(cfg_in.pol_low));
    endproperty
    a_reg_out: assert property (p_reg_out) else $error("registered output wrong"); // see [R11]

    property p_fb_sel;
        fb_out == ((fb_sel == spa_pkg::SPA_FB_PIN) ? pin_sync_in
                   : (fb_sel == spa_pkg::SPA_FB_COMB) ? comb_r : q_eff);
    endproperty
    a_fb_sel: assert property (p_fb_sel) else $error("feedback source wrong"); // see [R12]

    property p_oe;
        1'b1 |=> oe_r == $past(oe_term_in);
    endproperty
    a_oe: assert property (p_oe) else $error("output enable not followed"); // see [R13]
endmodule : spa_macrocell
`default_nettype wire

// ===== logic/spa_pkg.sv
// Purpose: Shared constants and types for the sum-of-products macrocell array
// Assumes: One 10 MHz clock, AXI4-Lite register access
// Notes: Input line 2*i is signal i true, line 2*i+1 its complement
package spa_pkg;
    localparam int N_DIN = 10;
    localparam int N_IO = 8;
    localparam int N_SIG = 18;
    localparam int N_LINES = 36;
    localparam int N_TERMS = 74;
    localparam int N_SOP = 64;
    localparam int TERMS_PER_SUM = 8;
    localparam int T_OE_BASE = 64;
    localparam int T_PRESET = 72;
    localparam int T_CLEAR = 73;
    localparam int CFG_BITS = 4;

    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_TSEL = 8'h04;
    localparam logic [7:0] A_FUSE_LO = 8'h08;
    localparam logic [7:0] A_FUSE_HI = 8'h0C;
    localparam logic [7:0] A_CFG = 8'h10;
    localparam logic [7:0] A_STAT = 8'h14;

    localparam int CTRL_RUN_BIT = 0;
    localparam logic CTRL_RUN_RST = 1'b0;
    localparam logic [6:0] TSEL_RST = 7'h00;
    localparam logic [6:0] TSEL_LAST = 7'h49;
    localparam logic [35:0] FUSE_RST = 36'hF_FFFF_FFFF;
    localparam logic [31:0] CFG_RST = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Feedback select, coded as {D, C}
    typedef enum logic [1:0] {
        SPA_FB_REG = 2'h0,
        SPA_FB_COMB = 2'h1,
        SPA_FB_BAD = 2'h2,
        SPA_FB_PIN = 2'h3
    } spa_fb_t;

    // Packed LSB first: A = pol_low, B = src_reg, C, D
    typedef struct packed {
        logic fb_d;
        logic fb_c;
        logic src_reg;
        logic pol_low;
    } spa_cfg_t;

    typedef struct packed {
        logic preset;
        logic clear;
    } spa_glob_t;
endpackage : spa_pkg

// ===== test/spa_array_tb.sv
// Purpose: Self-checking bench for the macrocell array
// Assumes: Terms 0, 8, 64, 65, 72, 73 programmed; others left all connected
// Notes: Macrocell 1 shows the feedback of macrocell 0
`timescale 1ns/1ns
`default_nettype none
module spa_array_tb;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [9:0] din = 10'h000;
    logic [7:0] ext_val = 8'h00;
    logic [7:0] pin_lvl, pin_out, pin_oe, awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] seed = 32'hB7CA69DA;
    int fail_count = 0;
    int n_tests = 0;

    always #50 clk_in = ~clk_in;

    spa_array spa_array_i (.clk_in(clk_in), .reset_n_in(reset_n_in), .din_in(din), .pin_in(pin_lvl),
        .pin_out_out(pin_out), .pin_oe_out(pin_oe), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
        .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF),
        .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
        .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
        .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready));

    spa_pin_partner spa_pin_partner_i (.oe_in(pin_oe), .drv_in(pin_out), .ext_val_in(ext_val),
        .level_out(pin_lvl));

    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    task automatic hang(input string what);
        fail_count++;
        $display("BAD %0t no answer on %s", $time, what);
        give_verdict();
    endtask : hang

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t word %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t pin bit %b expected %b", $time, got, exp);
        end
    endtask : chk_bit

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge clk_in);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_in);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        if (n == 50) hang("write");
        bready <= 1'b0;
        chk_word({30'h0, bresp}, {30'h0, er});
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge clk_in);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_in);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        if (n == 50) hang("read");
        d = rdata;
        rready <= 1'b0;
        chk_word({30'h0, rresp}, {30'h0, er});
    endtask : bus_rd

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : xs

    // Steady state {q0, out0, fb0}: sum0 = din0, oe0 = din1, preset = din2, clear = din3
    function automatic logic [2:0] expect_io(input logic [3:0] cfg, input logic [9:0] d, input logic ev);
        logic q0, out0, fb0;
        q0 = d[3] ? 1'b0 : (d[2] ? 1'b1 : d[0]);
        out0 = (cfg[1] ? q0 : d[0]) ^ cfg[0];
        fb0 = cfg[2] ? (cfg[3] ? (d[1] ? out0 : ev) : d[0]) : q0;
        return {q0, out0, fb0};
    endfunction : expect_io

    initial begin
        repeat (100000) @(posedge clk_in);
        hang("run");
    end

    initial begin
        logic [31:0] r;
        logic [2:0] e;
        logic [6:0] term_no [6] = '{7'h00, 7'h08, 7'h40, 7'h41, 7'h48, 7'h49};
        int line_no [6] = '{0, 20, 2, 3, 4, 6};
        repeat (20) @(posedge clk_in);
        reset_n_in <= 1'b1;
        bus_rd(spa_pkg::A_STAT, r, spa_pkg::RESP_OKAY);
        chk_word(r & 32'h0000_FFFF, 32'h0000_0000);
        bus_rd(spa_pkg::A_FUSE_LO, r, spa_pkg::RESP_OKAY);
        chk_word(r, 32'hFFFF_FFFF);
        bus_rd(8'h18, r, spa_pkg::RESP_SLVERR);
        chk_word(r, 32'h0000_0000);
        bus_wr(spa_pkg::A_STAT, 32'h0000_0000, spa_pkg::RESP_SLVERR);
        for (int k = 0; k < 6; k++) begin
            bus_wr(spa_pkg::A_TSEL, {25'h0, term_no[k]}, spa_pkg::RESP_OKAY);
            bus_wr(spa_pkg::A_FUSE_LO, 32'h1 << line_no[k], spa_pkg::RESP_OKAY);
            bus_wr(spa_pkg::A_FUSE_HI, 32'h0000_0000, spa_pkg::RESP_OKAY);
        end
        bus_rd(spa_pkg::A_FUSE_LO, r, spa_pkg::RESP_OKAY);
        chk_word(r, 32'h0000_0040);
        bus_wr(spa_pkg::A_TSEL, 32'h0000_004A, spa_pkg::RESP_OKAY);
        bus_rd(spa_pkg::A_FUSE_LO, r, spa_pkg::RESP_SLVERR);
        for (int c = 0; c < 16; c++) begin
            bus_wr(spa_pkg::A_CTRL, 32'h0000_0000, spa_pkg::RESP_OKAY);
            bus_wr(spa_pkg::A_CFG, c, spa_pkg::RESP_OKAY);
            bus_rd(spa_pkg::A_CFG, r, spa_pkg::RESP_OKAY);
            chk_word(r, c);
            bus_wr(spa_pkg::A_CTRL, 32'h0000_0001, spa_pkg::RESP_OKAY);
            if (c == 0) bus_wr(spa_pkg::A_CFG, 32'h0000_0005, spa_pkg::RESP_SLVERR);
            for (int k = 0; k < 4; k++) begin
                seed = xs(seed);
                // Corners first: clear with preset, then preset with a low sum
                din <= (k == 0) ? {seed[9:4], 4'hC} : (k == 1) ? {seed[9:4], 2'b01, seed[1], 1'b0} : seed[9:0];
                ext_val <= seed[17:10];
                repeat (16) @(posedge clk_in);
                e = expect_io(c[3:0], din, ext_val[0]);
                chk_bit(pin_oe[0], din[1]);
                chk_bit(pin_oe[1], ~din[1]);
                chk_word({26'h0, pin_oe[7:2]}, 32'h0000_0000);
                chk_word({26'h0, pin_out[7:2]}, 32'h0000_0000);
                if (din[1]) chk_bit(pin_out[0], e[1]);
                else chk_bit(pin_out[1], e[0]);
                bus_rd(spa_pkg::A_STAT, r, spa_pkg::RESP_OKAY);
                chk_bit(r[0], e[2]);
                chk_word(r & 32'h00FC_FF00, {8'h00, ext_val[7:2], 2'b00, 6'h00, ~din[1], din[1], 8'h00});
            end
        end
        give_verdict();
    end
endmodule : spa_array_tb
`default_nettype wire

// ===== test/spa_pin_partner.sv
// Purpose: Outside logic on the eight I/O pins
// Assumes: Pin enable high means the array drives the pin
// Notes: Resolves each pin from both drivers
`timescale 1ns/1ns
`default_nettype none
module spa_pin_partner (
    input wire logic [7:0] oe_in,
    input wire logic [7:0] drv_in,
    input wire logic [7:0] ext_val_in,
    output logic [7:0] level_out
);
    // Outside logic drives a pin only while the array leaves it free
    always_comb begin
        for (int m = 0; m < 8; m++) begin
            level_out[m] = oe_in[m] ? drv_in[m] : ext_val_in[m];
        end
    end
endmodule : spa_pin_partner
`default_nettype wire
